/* common/spt_pkg.sv */
package spt_pkg;

	// ==========================================================
	// timing
	localparam int CLK_FREQ_MHZ = 250;
	localparam int TICK_US = 1;
	localparam int TICK_CYCLES = TICK_US * CLK_FREQ_MHZ;
	localparam int MAX_US = 1000000;
	localparam int US_W = 20;

	// ==========================================================
	// register map, byte offsets
	localparam int ADDR_W = 4;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_DELAY = 8'h04;
	localparam logic [7:0] OFF_WIDTH = 8'h08;
	localparam logic [7:0] CH_STRIDE = 8'h10;
	localparam logic [7:0] OFF_OUT_MAP = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;

	// ==========================================================
	// field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_REF_BIT = 1;
	localparam int MAP_A_SEL_BIT = 0;
	localparam int MAP_A_POL_BIT = 1;
	localparam int MAP_B_SEL_BIT = 2;
	localparam int MAP_B_POL_BIT = 3;
	localparam int STAT_STROBE_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_CH_STRIDE = 2;
	localparam int STAT_OUT_A_BIT = 4;
	localparam int STAT_OUT_B_BIT = 5;

	// ==========================================================
	// reset values
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [US_W-1:0] DELAY_RST = 20'h0_0000;
	localparam logic [US_W-1:0] WIDTH_RST = 20'h0_0000;
	localparam logic [3:0] MAP_RST = 4'h4;

	typedef enum {ST_IDLE, ST_DELAY, ST_PULSE} spt_state_t;

endpackage

/* core/spt_channel.sv */
`timescale 1ns/1ps
module spt_channel #(
	parameter int TICK_CYCLES = spt_pkg::TICK_CYCLES,
	parameter int US_W = spt_pkg::US_W
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic ref_sel,
	input wire logic [US_W-1:0] delay_us,
	input wire logic [US_W-1:0] width_us,
	input wire logic exposure_start,
	input wire logic readout_start,
	output logic strobe,
	output logic busy
);

	localparam int SUB_W = $clog2(TICK_CYCLES);
	localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(TICK_CYCLES - 1);
	localparam logic [US_W-1:0] REM_ONE = US_W'(1);

	if (TICK_CYCLES < 2) begin : g_chk
		$error("tick must span at least two clocks");
	end

	spt_pkg::spt_state_t state_reg;
	logic [US_W-1:0] rem_reg;
	logic [US_W-1:0] width_lat_reg;
	logic [SUB_W-1:0] sub_reg;
	logic strobe_reg;
	logic event_hit;
	logic tick;

	assign event_hit = ref_sel ? readout_start : exposure_start;
	assign tick = (sub_reg == SUB_LAST);
	assign strobe = strobe_reg;
	assign busy = (state_reg != spt_pkg::ST_IDLE);

	// ==========================================================
	// microsecond prescaler, restarted per event so delay is exact
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sub_reg <= '0;
		end else if (state_reg == spt_pkg::ST_IDLE || tick) begin
			sub_reg <= '0;
		end else begin
			sub_reg <= sub_reg + 1'b1;
		end
	end

	// ==========================================================
	// delay then pulse sequencer
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= spt_pkg::ST_IDLE;
			rem_reg <= '0;
			width_lat_reg <= '0;
			strobe_reg <= 1'b0;
		end else begin
			case (state_reg)
				spt_pkg::ST_IDLE: begin
					// zero width never leaves idle
					if (enable && event_hit && width_us != '0) begin
						width_lat_reg <= width_us;
						if (delay_us == '0) begin
							state_reg <= spt_pkg::ST_PULSE;
							rem_reg <= width_us;
							strobe_reg <= 1'b1;
						end else begin
							state_reg <= spt_pkg::ST_DELAY;
							rem_reg <= delay_us;
						end
					end
				end
				spt_pkg::ST_DELAY: begin
					if (!enable) begin
						state_reg <= spt_pkg::ST_IDLE;
					end else if (tick) begin
						if (rem_reg == REM_ONE) begin
							state_reg <= spt_pkg::ST_PULSE;
							rem_reg <= width_lat_reg;
							strobe_reg <= 1'b1;
						end else begin
							rem_reg <= rem_reg - 1'b1;
						end
					end
				end
				spt_pkg::ST_PULSE: begin
					if (!enable) begin
						state_reg <= spt_pkg::ST_IDLE;
						strobe_reg <= 1'b0;
					end else if (tick) begin
						if (rem_reg == REM_ONE) begin
							state_reg <= spt_pkg::ST_IDLE;
							strobe_reg <= 1'b0;
						end else begin
							rem_reg <= rem_reg - 1'b1;
						end
					end
				end
				default: begin
					state_reg <= spt_pkg::ST_IDLE;
					strobe_reg <= 1'b0;
				end
			endcase
		end
	end

endmodule // spt_channel

/* core/spt_top.sv */
`timescale 1ns/1ps
module spt_top #(
	parameter int TICK_CYCLES = spt_pkg::TICK_CYCLES,
	parameter int MAX_US = spt_pkg::MAX_US,
	parameter int US_W = spt_pkg::US_W
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [spt_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic exposure_start,
	input wire logic readout_start,
	output logic external_output_a,
	output logic external_output_b
);

	localparam int NCH = 2;
	localparam logic [US_W-1:0] MAX_VAL = US_W'(MAX_US);

	if ((64'd1 << US_W) <= 64'(MAX_US)) begin : g_chk_w
		$error("value width too narrow for the largest setting");
	end
	if (US_W > 32) begin : g_chk_bus
		$error("value width exceeds bus width");
	end

	// ==========================================================
	// helpers
	function automatic logic hit(
		input logic [spt_pkg::ADDR_W-1:0] addr,
		input logic [7:0] off
	);
		hit = (addr == off[spt_pkg::ADDR_W+1:2]);
	endfunction

	function automatic logic [7:0] ch_off(input logic [7:0] base, input int ch);
		ch_off = base + 8'(ch * 16'(spt_pkg::CH_STRIDE));
	endfunction

	function automatic logic [31:0] lane_merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0] be
	);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		lane_merge = (old & ~m) | (wd & m);
	endfunction

	// out-of-range settings saturate rather than wrap
	function automatic logic [US_W-1:0] clamp(input logic [31:0] v);
		if (v > 32'(MAX_US)) begin
			clamp = MAX_VAL;
		end else begin
			clamp = v[US_W-1:0];
		end
	endfunction

	// ==========================================================
	// bus handshake: one wait cycle per access
	logic ack_reg;
	logic req;
	logic wr_take;
	logic [31:0] readdata_reg;
	logic [31:0] rd_next;

	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_reg;
	assign wr_take = avs_write & ack_reg;
	assign avs_readdata = readdata_reg;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg;
		end
	end

	// ==========================================================
	// configuration registers
	logic [1:0] ctrl_reg [NCH];
	logic [US_W-1:0] delay_reg [NCH];
	logic [US_W-1:0] width_reg [NCH];
	logic [3:0] map_reg;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NCH; i++) begin
				ctrl_reg[i] <= spt_pkg::CTRL_RST;
				delay_reg[i] <= spt_pkg::DELAY_RST;
				width_reg[i] <= spt_pkg::WIDTH_RST;
			end
		end else if (wr_take) begin
			for (int i = 0; i < NCH; i++) begin
				if (hit(avs_address, ch_off(spt_pkg::OFF_CTRL, i))) begin
					ctrl_reg[i] <= 2'(lane_merge(32'(ctrl_reg[i]), avs_writedata,
						avs_byteenable));
				end
				if (hit(avs_address, ch_off(spt_pkg::OFF_DELAY, i))) begin
					delay_reg[i] <= clamp(lane_merge(32'(delay_reg[i]),
						avs_writedata, avs_byteenable));
				end
				if (hit(avs_address, ch_off(spt_pkg::OFF_WIDTH, i))) begin
					width_reg[i] <= clamp(lane_merge(32'(width_reg[i]),
						avs_writedata, avs_byteenable));
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			map_reg <= spt_pkg::MAP_RST;
		end else if (wr_take && hit(avs_address, spt_pkg::OFF_OUT_MAP)) begin
			if (avs_byteenable[0]) begin
				map_reg <= avs_writedata[3:0];
			end
		end
	end

	// ==========================================================
	// strobe channels
	logic [NCH-1:0] strobe;
	logic [NCH-1:0] busy;

	for (genvar g = 0; g < NCH; g++) begin : g_ch
		spt_channel #(
			.TICK_CYCLES(TICK_CYCLES),
			.US_W(US_W)
		) u_ch (
			.ref_clk(ref_clk),
			.reset_n(reset_n),
			.enable(ctrl_reg[g][spt_pkg::CTRL_EN_BIT]),
			.ref_sel(ctrl_reg[g][spt_pkg::CTRL_REF_BIT]),
			.delay_us(delay_reg[g]),
			.width_us(width_reg[g]),
			.exposure_start(exposure_start),
			.readout_start(readout_start),
			.strobe(strobe[g]),
			.busy(busy[g])
		);
	end

	// ==========================================================
	// output mapping, registered to keep pins glitch free
	logic out_a_reg;
	logic out_b_reg;
	logic src_a;
	logic src_b;

	assign src_a = map_reg[spt_pkg::MAP_A_SEL_BIT] ? strobe[1] : strobe[0];
	assign src_b = map_reg[spt_pkg::MAP_B_SEL_BIT] ? strobe[1] : strobe[0];

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_a_reg <= 1'b0;
			out_b_reg <= 1'b0;
		end else begin
			out_a_reg <= src_a ^ map_reg[spt_pkg::MAP_A_POL_BIT];
			out_b_reg <= src_b ^ map_reg[spt_pkg::MAP_B_POL_BIT];
		end
	end

	assign external_output_a = out_a_reg;
	assign external_output_b = out_b_reg;

	// ==========================================================
	// read path
	always_comb begin
		rd_next = 32'h0000_0000;
		for (int i = 0; i < NCH; i++) begin
			if (hit(avs_address, ch_off(spt_pkg::OFF_CTRL, i))) begin
				rd_next = 32'(ctrl_reg[i]);
			end
			if (hit(avs_address, ch_off(spt_pkg::OFF_DELAY, i))) begin
				rd_next = 32'(delay_reg[i]);
			end
			if (hit(avs_address, ch_off(spt_pkg::OFF_WIDTH, i))) begin
				rd_next = 32'(width_reg[i]);
			end
		end
		if (hit(avs_address, spt_pkg::OFF_OUT_MAP)) begin
			rd_next = 32'(map_reg);
		end
		if (hit(avs_address, spt_pkg::OFF_STATUS)) begin
			for (int i = 0; i < NCH; i++) begin
				rd_next[spt_pkg::STAT_STROBE_BIT + i * spt_pkg::STAT_CH_STRIDE] = strobe[i];
				rd_next[spt_pkg::STAT_BUSY_BIT + i * spt_pkg::STAT_CH_STRIDE] = busy[i];
			end
			rd_next[spt_pkg::STAT_OUT_A_BIT] = out_a_reg;
			rd_next[spt_pkg::STAT_OUT_B_BIT] = out_b_reg;
		end
	end

	// read data captured in the wait cycle, steady while ack is high
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			readdata_reg <= 32'h0000_0000;
		end else if (avs_read && !ack_reg) begin
			readdata_reg <= rd_next;
		end
	end

endmodule // spt_top

/* sim/spt_lamp.sv */
`timescale 1ns/1ps
module spt_lamp #(
	parameter bit ACTIVE_LOW = 1'b0
) (
	input wire logic level,
	output int pulses,
	output time t_on,
	output time on_ns
);
	logic lit;
	assign lit = level ^ ACTIVE_LOW;
	initial pulses = 0;
	// lamp only sees light: time of turn-on and length of each flash
	always @(lit) begin
		if (lit === 1'b1) begin
			t_on = $time;
		end else if ($time > 0) begin
			on_ns = $time - t_on;
			pulses++;
		end
	end
endmodule // spt_lamp

/* sim/spt_top_assertions.sv */
`timescale 1ns/1ps
module spt_chk #(
	parameter int TICK_CYCLES = 4
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [spt_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic exposure_start,
	input wire logic readout_start,
	input wire logic external_output_a,
	input wire logic external_output_b
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	logic req;
	assign req = avs_read | avs_write;
	logic wr_take;
	logic pol_a_reg;
	logic pol_b_reg;
	logic pol_a_q;
	logic pol_b_q;
	logic lit_a;
	logic lit_b;
	assign wr_take = avs_write && !avs_waitrequest;
	// polarity as the output stage applies it, one cycle behind the write
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pol_a_reg <= spt_pkg::MAP_RST[spt_pkg::MAP_A_POL_BIT];
			pol_b_reg <= spt_pkg::MAP_RST[spt_pkg::MAP_B_POL_BIT];
			pol_a_q <= spt_pkg::MAP_RST[spt_pkg::MAP_A_POL_BIT];
			pol_b_q <= spt_pkg::MAP_RST[spt_pkg::MAP_B_POL_BIT];
		end else begin
			if (wr_take && avs_address == 4'h8 && avs_byteenable[0]) begin
				pol_a_reg <= avs_writedata[spt_pkg::MAP_A_POL_BIT];
				pol_b_reg <= avs_writedata[spt_pkg::MAP_B_POL_BIT];
			end
			pol_a_q <= pol_a_reg;
			pol_b_q <= pol_b_reg;
		end
	end
	assign lit_a = external_output_a ^ pol_a_q;
	assign lit_b = external_output_b ^ pol_b_q;
	// ====
	// bus
	sequence s_wr_ctrl;
		avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0];
	endsequence
	sequence s_rd_ctrl;
		avs_read && avs_waitrequest && avs_address == 4'h0;
	endsequence
	AST_REQ_WAIT: assert property ($rose(req) |-> avs_waitrequest) else $error("no wait cycle");
	AST_ONE_WAIT: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait too long");
	AST_IDLE_NOWAIT: assert property (!req |-> !avs_waitrequest) else $error("idle wait");
	AST_UNMAPPED_ZERO: assert property (avs_read && avs_waitrequest && avs_address > 4'h9
		|=> avs_readdata == 32'h0000_0000) else $error("unmapped not zero");
	AST_RD_HOLD: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("readdata moved");
	AST_WR_RD_CTRL: assert property (s_wr_ctrl ##1 s_rd_ctrl
		|=> avs_readdata[1:0] == $past(avs_writedata[1:0], 2)) else $error("ctrl readback");
	// ====
	// outputs
	// assumes TICK_CYCLES >= 4: a lit phase of 1 us stands at least 4 cycles;
	// only the lit phase: a retrigger may leave a one-cycle dark gap
	// quiet bus in the rise cycle and the two before it, since a disable or a remap may cut it short
	sequence s_bus_quiet;
		!avs_write && !$past(avs_write) && !$past(avs_write, 2);
	endsequence
	AST_A_MIN: assert property ($rose(lit_a) ##0 s_bus_quiet |=> lit_a[*3])
		else $error("output a pulse too short");
	AST_B_MIN: assert property ($rose(lit_b) ##0 s_bus_quiet |=> lit_b[*3])
		else $error("output b pulse too short");
endmodule // spt_chk
bind spt_top spt_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk(.ref_clk(ref_clk), .reset_n(reset_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.exposure_start(exposure_start), .readout_start(readout_start),
	.external_output_a(external_output_a), .external_output_b(external_output_b));

/* sim/test_strobe_pulse_timer.sv */
`timescale 1ns/1ps
module test_strobe_pulse_timer;
	localparam int TK = 4;
	logic ref_clk = 0, reset_n = 0, avs_read = 0, avs_write = 0;
	logic exposure_start = 0, readout_start = 0;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 32'h0000_0000, rd, v;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, external_output_a, external_output_b;
	int bad_count = 0, n_compared = 0, pa, pb, na, nb, d, w;
	time ta, wa, ts;
	bit ch, r, en;
	always #2 ref_clk = ~ref_clk;
	spt_top #(.TICK_CYCLES(TK)) DUT(.ref_clk(ref_clk), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.exposure_start(exposure_start), .readout_start(readout_start),
		.external_output_a(external_output_a), .external_output_b(external_output_b));
	spt_lamp #(.ACTIVE_LOW(1'b1)) lamp_a(.level(external_output_a), .pulses(pa), .t_on(ta),
		.on_ns(wa));
	spt_lamp #(.ACTIVE_LOW(1'b0)) lamp_b(.level(external_output_b), .pulses(pb), .t_on(),
		.on_ns());
	// ====
	// helpers
	function logic [31:0] sat(input logic [31:0] x);
		return (x > 32'd1000000) ? 32'd1000000 : x;
	endfunction
	function logic [31:0] rise_ns(input int dl);
		return 32'((TK * dl + 1) * 4);
	endfunction
	task finish_test;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// waitrequest and read data taken at the rising edge that ends the access
	task bus_wait;
		int n;
		for (n = 0; n < 20; n++) begin
			@(posedge ref_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		rd = avs_readdata;
		if (n == 20) begin
			bad_count++;
			finish_test();
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] dt, input logic [3:0] be);
		// a write just released needs its edge before the next one rises
		if (avs_write) @(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= dt;
		avs_byteenable <= be;
		avs_write <= 1'b1;
		bus_wait();
		avs_write <= 1'b0;
	endtask
	task rdc(input logic [3:0] a, input logic [31:0] exp);
		if (avs_read) @(posedge ref_clk);
		avs_address <= a;
		avs_read <= 1'b1;
		bus_wait();
		avs_read <= 1'b0;
		chk(rd, exp);
	endtask
	task fire(input bit sel);
		if (exposure_start || readout_start) @(posedge ref_clk);
		if (sel) readout_start <= 1'b1;
		else exposure_start <= 1'b1;
		@(posedge ref_clk);
		ts = $time;
		exposure_start <= 1'b0;
		readout_start <= 1'b0;
	endtask
	// ====
	// sequence
	initial begin
		void'($urandom(32));
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		for (int a = 0; a < 12; a++) rdc(4'(a), (a == 8) ? 32'h0000_0004 : 32'h0);
		wr(4'hb, 32'hffff_ffff, 4'hf);
		rdc(4'hb, 32'h0000_0000);
		$display("test regs done");
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 0 : (i == 1) ? 1000000 : (i == 2) ? 1000001 : $urandom & 32'h000f_ffff;
			wr(4'h5, v, 4'hf);
			rdc(4'h5, sat(v));
			wr(4'h6, v, 4'hf);
			rdc(4'h6, sat(v));
		end
		wr(4'h5, 32'h0, 4'hf);
		wr(4'h5, 32'h0001_2345, 4'h3);
		rdc(4'h5, 32'h0000_2345);
		wr(4'h0, 32'h3, 4'h1);
		rdc(4'h0, 32'h3);
		$display("test range done");
		for (int i = 0; i < 8; i++) begin
			ch = i[0];
			r = i[1];
			en = (i != 6);
			d = (i == 0) ? 0 : $urandom % 3;
			w = (i == 5) ? 0 : 1 + $urandom % 3;
			wr({1'b0, ~ch, 2'b00}, 32'h0, 4'hf);
			wr({1'b0, ch, 2'b00}, {30'h0, r, en}, 4'hf);
			wr({1'b0, ch, 2'b01}, 32'(d), 4'hf);
			wr({1'b0, ch, 2'b10}, 32'(w), 4'hf);
			// output b follows the idle channel first, the active one later
			wr(4'h8, {28'h0, 1'b0, (i[2] ? ch : ~ch), 1'b1, ch}, 4'hf);
			// a polarity flip reaches the pin a cycle later: let it settle
			repeat (2) @(posedge ref_clk);
			na = pa;
			nb = pb;
			fire(~r);
			repeat (TK * (d + w) + 4) @(posedge ref_clk);
			fire(r);
			v = 32'(ts);
			// second event lands while busy, or in idle when w is 0, and must be dropped
			if (i[0]) fire(r);
			repeat (TK * (d + w) + 8) @(posedge ref_clk);
			chk(32'(pa - na), 32'(en && w != 0));
			chk(32'(pb - nb), 32'(i[2] && en && w != 0));
			if (en && w != 0) begin
				chk(32'(ta) - v, rise_ns(d));
				chk(32'(wa), 32'(TK * w * 4));
			end
			$display("test pulse %0d done", i);
		end
		finish_test();
	end
endmodule // test_strobe_pulse_timer
